// ===== i2ccr_bus_model.sv
// Remote bus master model with open-drain lines
`timescale 1ns/1ps
`default_nettype none
module i2ccr_bus_model (
   input wire logic scl_in,
   output logic scl_out,
   output logic sda_out
);
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // One clock pulse, waiting out any stretch
   task automatic pulse();
      #32 scl_out = 1'b1;
      #1;
      wait (scl_in === 1'b1);
      #31 scl_out = 1'b0;
   endtask
   // Eight bits msb first, then the acknowledge clock; clock left low
   task automatic send_byte(input logic [7:0] b);
      #2;
      for (int i = 7; i >= 0; i--) begin
         sda_out = b[i];
         pulse();
      end
      sda_out = 1'b1;
      pulse();
   endtask
   // Start condition then one byte; pins move off the clock edges
   task automatic start_byte(input logic [7:0] b);
      #2 sda_out = 1'b0;
      #32 scl_out = 1'b0;
      send_byte(b);
   endtask
   // Stop condition; lines left released
   task automatic stop();
      #2 scl_out = 1'b0;
      #32 sda_out = 1'b0;
      pulse();
      scl_out = 1'b1;
      #32 sda_out = 1'b1;
      #32;
   endtask
endmodule // i2ccr_bus_model
`default_nettype wire

// ===== i2ccr_ctrl.sv
// I2C bus control register with enable, exit and stretch release logic
// Functional notes
// R1: Reset clears the eight-bit control register to zero.
// R2: Control register written as a byte at its fixed address; bit writes via read-modify-write.
// R3: Software changes stop-irq, timing and ack bits only when disabled or stretching.
// R4: Enable low stops the bus logic and clears the bus status register.
// R5: Software raises enable only while both bus lines are high.
// R6: Enable changes only by software write or reset.
// R7: Exit command abandons the transfer, enters standby, releases both lines.
// R8: Exit bit clears itself after execution and on reset.
// R9: Exit clears start/stop triggers, master, ext, match, transmit, ack, start flags.
// R10: Standby after exit lasts until stop, or address match/extension after start; the code leaves standby at every start condition.
// R11: Software uses exit when an unrelated extension code arrives.
// R12: Writing one to release ends the stretch; bit clears itself; zero keeps it.
// R13: Release at ninth-clock stretch while transmitting frees data line, clears transmit flag.
// R14: Timing select bit 3, stop-irq enable bit 4, start bit 1, stop bit 0.
// R15: With the clock gate low, control registers hold initial values, writes ignored.
// R16: Enable bit 7, exit bit 6, release bit 5, ack enable bit 2.
`timescale 1ns/1ps
`default_nettype none
`include "i2ccr_regs.svh"

module i2ccr_ctrl
   import i2ccr_pkg::*;
#(
   parameter logic [6:0] LOCAL_ADDR = 7'h21
) (
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [19:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [3:0] PSTRB_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   input wire logic SCL_IN,
   output logic SCL_OUT,
   output logic SCL_OE_OUT,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE_OUT,
   output logic IRQ_OUT
);

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // One-hot select: ctrl0, gate, bstat, istat, iclr, ien
   function automatic logic [5:0] reg_sel(input logic [19:0] a);
      reg_sel = {a == `I2CCR_ADDR_IEN, a == `I2CCR_ADDR_ICLR,
         a == `I2CCR_ADDR_ISTAT, a == `I2CCR_ADDR_BSTAT,
         a == `I2CCR_ADDR_GATE, a == `I2CCR_ADDR_CTRL0};
   endfunction

   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [31:0] prdata_reg, prdata_next;
   logic gate_reg, gate_next;
   logic [7:0] ctrl_reg, ctrl_next;
   logic [7:0] bstat_reg, bstat_next;
   logic [`I2CCR_IRQ_W-1:0] ist_reg, ist_next, ien_reg, ien_next;
   logic irq_reg, irq_next;
   logic [1:0] scl_sync_reg, sda_sync_reg;
   logic scl_d_reg, sda_d_reg;
   i2ccr_state_t state_reg, state_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic addr_ph_reg, addr_ph_next;
   logic at9_reg, at9_next;
   logic scl_oe_reg, scl_oe_next;
   logic sda_oe_reg, sda_oe_next;
   logic [`I2CCR_IRQ_W-1:0] ev;
   logic [5:0] sel;
   logic commit, wr, bus_start, bus_stop, scl_rise, scl_fall, op;
   logic scl_s, sda_s;

   // ----------------------------------------
   // Bus line synchronisers
   // ----------------------------------------
   // Two flops per line, then a delayed copy
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], SCL_IN};
         sda_sync_reg <= {sda_sync_reg[0], SDA_IN};
         scl_d_reg <= scl_sync_reg[1];
         sda_d_reg <= sda_sync_reg[1];
      end
   end

   // Line events from synchronised levels only
   assign scl_s = scl_sync_reg[1];
   assign sda_s = sda_sync_reg[1];
   assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
   assign scl_rise = ~scl_d_reg & scl_s;
   assign scl_fall = scl_d_reg & ~scl_s;

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   // One wait state; commit at the edge that sees pready
   assign sel = reg_sel(PADDR_IN);
   assign commit = PSEL_IN & PENABLE_IN & pready_reg;
   assign wr = commit & PWRITE_IN & PSTRB_IN[0];

   // Response and read data
   always_comb begin
      pready_next = PSEL_IN & PENABLE_IN & ~pready_reg;
      pslverr_next = PSEL_IN & PENABLE_IN & ~pready_reg & ~(|sel);
      prdata_next = 32'h0000_0000;
      unique case (1'b1)
         sel[0]: prdata_next = {24'h00_0000, ctrl_reg};
         sel[1]: prdata_next = {31'h0000_0000, gate_reg};
         sel[2]: prdata_next = {24'h00_0000, bstat_reg};
         sel[3]: prdata_next = {29'h0000_0000, ist_reg};
         sel[5]: prdata_next = {29'h0000_0000, ien_reg};
         default: prdata_next = 32'h0000_0000;
      endcase
      if (!(PSEL_IN & PENABLE_IN & ~pready_reg & ~PWRITE_IN)) begin
         prdata_next = 32'h0000_0000;
      end
   end

   // Response registers
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
      end
   end

   // ----------------------------------------
   // Control register and bus engine
   // ----------------------------------------
   assign op = gate_reg & ctrl_reg[`I2CCR_B_EN];

   // Next control, status and line drive
   always_comb begin
      gate_next = gate_reg;
      ctrl_next = ctrl_reg;
      bstat_next = bstat_reg;
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      addr_ph_next = addr_ph_reg;
      at9_next = at9_reg;
      scl_oe_next = scl_oe_reg;
      sda_oe_next = sda_oe_reg;
      ev = '0;
      if (wr && sel[1]) begin
         gate_next = PWDATA_IN[0];
      end
      // Release is a one-shot command
      ctrl_next[`I2CCR_B_WREL] = 1'b0; // R12
      if (!op) begin
         // Stopped: status cleared, lines free
         bstat_next = 8'h00; // R4
         state_next = I2CCR_IDLE; // R4
         cnt_next = 4'h0;
         addr_ph_next = 1'b0;
         scl_oe_next = 1'b0;
         sda_oe_next = 1'b0;
      end else if (ctrl_reg[`I2CCR_B_EXIT]) begin
         // Abandon transfer, clear flags
         ctrl_next[`I2CCR_B_EXIT] = 1'b0; // R8
         ctrl_next[`I2CCR_B_STT] = 1'b0; // R9
         ctrl_next[`I2CCR_B_SPT] = 1'b0; // R9
         bstat_next = 8'h00; // R9
         state_next = I2CCR_STANDBY; // R7
         scl_oe_next = 1'b0; // R7
         sda_oe_next = 1'b0; // R7
         cnt_next = 4'h0;
         addr_ph_next = 1'b0;
      end else if (bus_stop) begin
         // Stop ends any transfer or standby
         bstat_next[`I2CCR_S_STD] = 1'b0;
         bstat_next[`I2CCR_S_MSTS] = 1'b0;
         ctrl_next[`I2CCR_B_SPT] = 1'b0;
         state_next = I2CCR_IDLE; // R10
         scl_oe_next = 1'b0;
         sda_oe_next = 1'b0;
         ev[`I2CCR_I_STOP] = ctrl_reg[`I2CCR_B_SPIE];
      end else if (bus_start) begin
         // Start: count a fresh address byte
         bstat_next[`I2CCR_S_STD] = 1'b1;
         bstat_next[`I2CCR_S_COI] = 1'b0;
         bstat_next[`I2CCR_S_EXC] = 1'b0;
         bstat_next[`I2CCR_S_TRC] = 1'b0;
         state_next = I2CCR_XFER; // R10
         cnt_next = 4'h0;
         addr_ph_next = 1'b1;
         ev[`I2CCR_I_START] = 1'b1;
      end else begin
         unique case (state_reg)
            I2CCR_IDLE: begin
               // Free bus: start trigger takes mastership
               if (ctrl_reg[`I2CCR_B_STT]) begin
                  bstat_next[`I2CCR_S_MSTS] = 1'b1;
                  ctrl_next[`I2CCR_B_STT] = 1'b0;
               end
            end
            I2CCR_STANDBY: begin
               // Wait for stop or start, taken above
            end
            I2CCR_XFER: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_s};
                  cnt_next = cnt_reg + 4'h1;
                  if (cnt_reg == `I2CCR_CNT_8 && bstat_reg[`I2CCR_S_TRC]) begin
                     bstat_next[`I2CCR_S_ACKD] = ~sda_s;
                  end
               end else if (scl_fall && cnt_reg == `I2CCR_CNT_8) begin
                  // Eighth falling edge
                  if (addr_ph_reg) begin
                     if (shift_reg[7:1] == LOCAL_ADDR) begin
                        bstat_next[`I2CCR_S_COI] = 1'b1;
                        bstat_next[`I2CCR_S_TRC] = shift_reg[0];
                        sda_oe_next = ctrl_reg[`I2CCR_B_ACKE];
                     end else if (shift_reg[7:3] == `I2CCR_EXT_HI) begin
                        bstat_next[`I2CCR_S_EXC] = 1'b1;
                        at9_next = 1'b0;
                        scl_oe_next = 1'b1;
                        state_next = I2CCR_STRETCH;
                        ev[`I2CCR_I_STRETCH] = 1'b1;
                     end else begin
                        state_next = I2CCR_IDLE;
                     end
                  end else if (!ctrl_reg[`I2CCR_B_WTIM]) begin
                     at9_next = 1'b0;
                     scl_oe_next = 1'b1;
                     state_next = I2CCR_STRETCH;
                     ev[`I2CCR_I_STRETCH] = 1'b1;
                  end else if (!bstat_reg[`I2CCR_S_TRC]) begin
                     sda_oe_next = ctrl_reg[`I2CCR_B_ACKE];
                  end
               end else if (scl_fall && cnt_reg == `I2CCR_CNT_9) begin
                  // Ninth falling edge; transmitter holds data low
                  cnt_next = 4'h0;
                  addr_ph_next = 1'b0;
                  sda_oe_next = bstat_reg[`I2CCR_S_TRC];
                  if (addr_ph_reg || ctrl_reg[`I2CCR_B_WTIM]) begin
                     at9_next = 1'b1;
                     scl_oe_next = 1'b1;
                     state_next = I2CCR_STRETCH;
                     ev[`I2CCR_I_STRETCH] = 1'b1;
                  end
               end
            end
            I2CCR_STRETCH: begin
               // Written one releases, zero keeps stretching
               if (ctrl_reg[`I2CCR_B_WREL]) begin
                  scl_oe_next = 1'b0; // R12
                  state_next = I2CCR_XFER; // R12
                  if (at9_reg && bstat_reg[`I2CCR_S_TRC]) begin
                     sda_oe_next = 1'b0; // R13
                     bstat_next[`I2CCR_S_TRC] = 1'b0; // R13
                  end
               end
            end
            default: state_next = I2CCR_IDLE;
         endcase
      end
      // Software write to control, only when gated in
      if (wr && sel[0] && gate_reg) begin
         ctrl_next = PWDATA_IN[7:0]; // R2 R6 R14 R16
      end
      if (!gate_reg) begin
         ctrl_next = `I2CCR_CTRL_RESET; // R15
         bstat_next = 8'h00; // R15
      end
   end

   // Control and engine registers
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         gate_reg <= 1'b0;
         ctrl_reg <= `I2CCR_CTRL_RESET; // R1
         bstat_reg <= 8'h00;
         state_reg <= I2CCR_IDLE;
         cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         addr_ph_reg <= 1'b0;
         at9_reg <= 1'b0;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else begin
         gate_reg <= gate_next;
         ctrl_reg <= ctrl_next;
         bstat_reg <= bstat_next;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         addr_ph_reg <= addr_ph_next;
         at9_reg <= at9_next;
         scl_oe_reg <= scl_oe_next;
         sda_oe_reg <= sda_oe_next;
      end
   end

   // ----------------------------------------
   // Interrupt status, clear and enable
   // ----------------------------------------
   // Set wins over a clear in the same cycle
   always_comb begin
      ist_next = ist_reg;
      ien_next = ien_reg;
      if (wr && sel[4]) begin
         ist_next = ist_reg & ~PWDATA_IN[`I2CCR_IRQ_W-1:0];
      end
      ist_next = ist_next | ev;
      if (wr && sel[5]) begin
         ien_next = PWDATA_IN[`I2CCR_IRQ_W-1:0];
      end
      irq_next = |(ist_next & ien_next);
   end

   // Interrupt registers
   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         ist_reg <= '0;
         ien_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         ist_reg <= ist_next;
         ien_reg <= ien_next;
         irq_reg <= irq_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Open-drain lines only ever pull low
   assign PRDATA_OUT = prdata_reg;
   assign PREADY_OUT = pready_reg;
   assign PSLVERR_OUT = pslverr_reg;
   assign SCL_OUT = 1'b0;
   assign SCL_OE_OUT = scl_oe_reg;
   assign SDA_OUT = 1'b0;
   assign SDA_OE_OUT = sda_oe_reg;
   assign IRQ_OUT = irq_reg;

endmodule // i2ccr_ctrl
`default_nettype wire

// ===== i2ccr_ctrl_props.sv
// Port assertions for the bus control block
`timescale 1ns/1ps
`default_nettype none
`include "i2ccr_regs.svh"
module i2ccr_ctrl_props (
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [19:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [3:0] PSTRB_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic PREADY_OUT,
   input wire logic PSLVERR_OUT,
   input wire logic SCL_IN,
   input wire logic SCL_OUT,
   input wire logic SCL_OE_OUT,
   input wire logic SDA_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE_OUT,
   input wire logic IRQ_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   // ----------------------------------------
   // Committed bus writes
   // ----------------------------------------
   sequence wr_at(logic [19:0] a);
      PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == a && PSTRB_IN[0];
   endsequence
   sequence ctrl_set(int b);
      wr_at(`I2CCR_ADDR_CTRL0) ##0 PWDATA_IN[b];
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready held too long");
   ready_wait_a: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT) else $error("no ready");
   rdata_idle_a: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0) else $error("read data outside ready");
   // Command bit lands one edge after the commit, the line drive one edge later
   stretch_end_a: assert property (ctrl_set(5) ##0 SCL_OE_OUT |-> ##2 !SCL_OE_OUT) else $error("stretch kept");
   data_free_a: assert property (ctrl_set(5) ##0 SCL_OE_OUT && SDA_OE_OUT |-> ##2 !SDA_OE_OUT)
      else $error("data held");
   exit_free_a: assert property (ctrl_set(6) |-> ##2 (!SCL_OE_OUT && !SDA_OE_OUT)[*3]) else $error("lines held");
   irq_mask_a: assert property (wr_at(`I2CCR_ADDR_IEN) ##0 PWDATA_IN[2:0] == 3'h0 |-> ##2 !IRQ_OUT)
      else $error("masked irq high");
   reset_quiet_a: assert property (disable iff (1'b0) !RSTN_IN |=> !PREADY_OUT && !SCL_OE_OUT && !IRQ_OUT)
      else $error("outputs active in reset");
endmodule // i2ccr_ctrl_props
`default_nettype wire

// ===== i2ccr_ctrl_tb.sv
// Testbench for the bus control block
`timescale 1ns/1ps
`default_nettype none
`include "i2ccr_regs.svh"
module i2ccr_ctrl_tb;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, scl_oe, sda_oe, scl_o, sda_o, irq, b_scl, b_sda, err;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata, r;
   wire logic scl_w = b_scl & (scl_oe ? scl_o : 1'b1);
   wire logic sda_w = b_sda & (sda_oe ? sda_o : 1'b1);
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   i2ccr_ctrl u_dut (.CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(4'hf), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .SCL_IN(scl_w), .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe), .SDA_IN(sda_w),
      .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .IRQ_OUT(irq));
   i2ccr_bus_model u_bus (.scl_in(scl_w), .scl_out(b_scl), .sda_out(b_sda));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask
   // One APB transfer, waits for ready
   task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [19:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
      apb(1'b0, a, 32'h0);
      chk(s, e, r & m);
   endtask
   task automatic oe_chk(input logic sc, input logic sd);
      int n;
      n = 0;
      // Let the synchronisers pass the last line change first
      repeat (6) @(posedge clk);
      while (scl_oe !== sc && n < 200) begin
         @(posedge clk);
         n++;
      end
      #1;
      chk("scl_oe", {31'h0, sc}, {31'h0, scl_oe});
      chk("sda_oe", {31'h0, sd}, {31'h0, sda_oe});
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rd(`I2CCR_ADDR_CTRL0, 32'hffffffff, 32'h0, "ctrl");
      apb(1'b1, `I2CCR_ADDR_CTRL0, 32'h9c);
      rd(`I2CCR_ADDR_CTRL0, 32'hff, 32'h0, "ctrl");
      apb(1'b0, 20'hf0260, 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      apb(1'b1, `I2CCR_ADDR_GATE, 32'h1);
      apb(1'b1, `I2CCR_ADDR_IEN, 32'h7);
      apb(1'b1, `I2CCR_ADDR_CTRL0, 32'h9c);
      rd(`I2CCR_ADDR_CTRL0, 32'hff, 32'h9c, "ctrl");
      u_bus.start_byte(8'h43);
      oe_chk(1'b1, 1'b1);
      rd(`I2CCR_ADDR_BSTAT, 32'h9a, 32'h1a, "bstat");
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, `I2CCR_ADDR_CTRL0, 32'hbc);
      oe_chk(1'b0, 1'b0);
      rd(`I2CCR_ADDR_BSTAT, 32'h08, 32'h0, "bstat");
      rd(`I2CCR_ADDR_CTRL0, 32'hff, 32'h9c, "ctrl");
      rd(`I2CCR_ADDR_ISTAT, 32'h4, 32'h4, "istat");
      apb(1'b1, `I2CCR_ADDR_ICLR, 32'h7);
      rd(`I2CCR_ADDR_ISTAT, 32'h7, 32'h0, "istat");
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b1, `I2CCR_ADDR_IEN, 32'h0);
      apb(1'b1, `I2CCR_ADDR_IEN, 32'h7);
      u_bus.stop();
      apb(1'b1, `I2CCR_ADDR_CTRL0, 32'h1c);
      rd(`I2CCR_ADDR_BSTAT, 32'hff, 32'h0, "bstat");
      rd(`I2CCR_ADDR_CTRL0, 32'hff, 32'h1c, "ctrl");
      apb(1'b1, `I2CCR_ADDR_CTRL0, 32'h9c);
      u_bus.start_byte(8'h42);
      oe_chk(1'b1, 1'b0);
      apb(1'b1, `I2CCR_ADDR_CTRL0, 32'hdf);
      oe_chk(1'b0, 1'b0);
      rd(`I2CCR_ADDR_CTRL0, 32'hff, 32'h9c, "ctrl");
      rd(`I2CCR_ADDR_BSTAT, 32'hff, 32'h0, "bstat");
      u_bus.send_byte(8'h42);
      oe_chk(1'b0, 1'b0);
      u_bus.stop();
      // Unrelated extension code: stretch at the eighth clock, then exit
      @(posedge clk);
      fork
         u_bus.start_byte(8'h08);
      join_none
      oe_chk(1'b1, 1'b0);
      rd(`I2CCR_ADDR_BSTAT, 32'h20, 32'h20, "bstat");
      apb(1'b1, `I2CCR_ADDR_CTRL0, 32'hdc);
      oe_chk(1'b0, 1'b0);
      rd(`I2CCR_ADDR_BSTAT, 32'hff, 32'h0, "bstat");
      wait fork;
      u_bus.stop();
      // Reset in mid-run clears control and gate
      @(posedge clk);
      rstn <= 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rd(`I2CCR_ADDR_CTRL0, 32'hff, 32'h0, "ctrl");
      rd(`I2CCR_ADDR_GATE, 32'h1, 32'h0, "gate");
      test_done();
   end
endmodule // i2ccr_ctrl_tb
bind i2ccr_ctrl i2ccr_ctrl_props u_props (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .PSEL_IN(PSEL_IN),
   .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN),
   .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT),
   .SCL_OE_OUT(SCL_OE_OUT), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// ===== i2ccr_pkg.sv
// Types shared by the bus control block
package i2ccr_pkg;
   // Engine states, one-hot
   typedef enum logic [3:0] {
      I2CCR_IDLE = 4'b0001,
      I2CCR_XFER = 4'b0010,
      I2CCR_STRETCH = 4'b0100,
      I2CCR_STANDBY = 4'b1000
   } i2ccr_state_t;
endpackage

// ===== i2ccr_regs.svh
// Register map, field positions and constants of the bus control block
`ifndef I2CCR_REGS_SVH
`define I2CCR_REGS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define I2CCR_ADDR_CTRL0 20'hf0230
`define I2CCR_ADDR_GATE 20'hf0240
`define I2CCR_ADDR_BSTAT 20'hf0244
`define I2CCR_ADDR_ISTAT 20'hf0248
`define I2CCR_ADDR_ICLR 20'hf024c
`define I2CCR_ADDR_IEN 20'hf0250
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define I2CCR_CTRL_RESET 8'h00
`define I2CCR_B_EN 7
`define I2CCR_B_EXIT 6
`define I2CCR_B_WREL 5
`define I2CCR_B_SPIE 4
`define I2CCR_B_WTIM 3
`define I2CCR_B_ACKE 2
`define I2CCR_B_STT 1
`define I2CCR_B_SPT 0
// ----------------------------------------
// Bus status register fields
// ----------------------------------------
`define I2CCR_S_MSTS 7
`define I2CCR_S_EXC 5
`define I2CCR_S_COI 4
`define I2CCR_S_TRC 3
`define I2CCR_S_ACKD 2
`define I2CCR_S_STD 1
// ----------------------------------------
// Interrupt status fields and misc
// ----------------------------------------
`define I2CCR_I_START 0
`define I2CCR_I_STOP 1
`define I2CCR_I_STRETCH 2
`define I2CCR_IRQ_W 3
`define I2CCR_CNT_8 4'h8
`define I2CCR_CNT_9 4'h9
`define I2CCR_EXT_HI 5'h01
`endif
